// File: btss_pkg.sv
// shared constants and types for the burst-of-two sram link
`default_nettype none
package btss_pkg;
  // ********************************************************
  // widths
  // ********************************************************
  localparam int DQ_W = 36;
  localparam int ADDR_W = 20;
  localparam int MEM_AW = 21;
  localparam int LANE_W = 9;
  localparam int LANE_N = 4;
  localparam int NIB_W = 4;
  localparam int NIB_N = 2;
  localparam int BURST_LEN = 2;
  localparam int A_BURST_BIT = 0;
  localparam int W_X8 = 8;
  localparam int W_X9 = 9;
  localparam int W_X18 = 18;
  // ********************************************************
  // link timing, in system clocks of 8 ns
  // ********************************************************
  localparam int K_HALF = 8;
  localparam int K_PER = 2 * K_HALF;
  localparam int PH_W = 4;
  localparam logic [PH_W-1:0] PH_LAST = 4'hF;
  localparam logic [PH_W-1:0] PH_KFALL = 4'h7;
  localparam logic [PH_W-1:0] PH_PRECMD = 4'hB;
  localparam logic [PH_W-1:0] PH_CMD = 4'hC;
  localparam logic [PH_W-1:0] PH_WORD1 = 4'h4;
  localparam logic [PH_W-1:0] PH_RD0 = 4'hE;
  localparam logic [PH_W-1:0] PH_RD1 = 4'h6;
  localparam int FIFO_DEPTH = 16;
  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [1:0] {
    CFG_X8 = 2'b00,
    CFG_X9 = 2'b01,
    CFG_X18 = 2'b10,
    CFG_X36 = 2'b11
  } btss_cfg_t;

  typedef struct packed {
    logic kClk;
    logic kClkN;
    logic cClk;
    logic cClkN;
    logic cycleDefineN;
    logic readNotWrite;
    logic [ADDR_W-1:0] addr;
    logic [NIB_N-1:0] nibbleWriteSelN;
    logic [LANE_N-1:0] laneWriteSelN;
    logic [DQ_W-1:0] dq;
  } btss_pins_t;

  // deselected; true clocks low and complements high, as the controller drives in reset
  localparam btss_pins_t PINS_IDLE = '{kClkN: 1'b1, cClkN: 1'b1, cycleDefineN: 1'b1,
    readNotWrite: 1'b1, nibbleWriteSelN: 2'h3, laneWriteSelN: 4'hF, default: '0};

  function automatic int btss_width(input btss_cfg_t c);
    btss_width = (c == CFG_X8) ? W_X8 : (c == CFG_X9) ? W_X9 :
      (c == CFG_X18) ? W_X18 : DQ_W;
  endfunction : btss_width
endpackage : btss_pkg
`default_nettype wire

// File: btss_link_if.sv
// link between the memory controller and the burst-of-two sram
`timescale 1ns/1ps
`default_nettype none
interface btss_link_if;
  logic kClk;
  logic kClkN;
  logic cClk;
  logic cClkN;
  logic cycleDefineN;
  logic readNotWrite;
  logic [btss_pkg::ADDR_W-1:0] addr;
  logic [btss_pkg::NIB_N-1:0] nibbleWriteSelN;
  logic [btss_pkg::LANE_N-1:0] laneWriteSelN;
  logic [btss_pkg::DQ_W-1:0] dqFromCtl;
  logic dqCtlOe;
  logic [btss_pkg::DQ_W-1:0] dqFromMem;
  logic dqMemOe;
  logic [btss_pkg::DQ_W-1:0] dqBus;

  // resolved shared data wire; a released bus settles low, as through a pull-down
  assign dqBus = dqMemOe ? dqFromMem : (dqCtlOe ? dqFromCtl : '0);

  modport mem (
    input kClk, kClkN, cClk, cClkN, cycleDefineN, readNotWrite, addr,
    input nibbleWriteSelN, laneWriteSelN, dqBus,
    output dqFromMem, dqMemOe
  );
  modport ctl (
    output kClk, kClkN, cClk, cClkN, cycleDefineN, readNotWrite, addr,
    output nibbleWriteSelN, laneWriteSelN, dqFromCtl, dqCtlOe,
    input dqBus
  );
endinterface : btss_link_if
`default_nettype wire

// File: btss_mem_end.sv
// sram end of the burst-of-two link: sync port, write merge, read launch
`timescale 1ns/1ps
`default_nettype none
module btss_mem_end #(
  parameter btss_pkg::btss_cfg_t CFG = btss_pkg::CFG_X36
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic singleClock,
  btss_link_if.mem link
);
  localparam int WIDTH = btss_pkg::btss_width(CFG);
  localparam int DW = btss_pkg::DQ_W;
  localparam int AW = btss_pkg::ADDR_W;
  localparam int MAW = btss_pkg::MEM_AW;
  localparam logic [DW-1:0] WMASK = {DW{1'b1}} >> (DW - WIDTH);

  // ********************************************************
  // pin synchroniser
  // ********************************************************
  btss_pkg::btss_pins_t pinsRaw;
  btss_pkg::btss_pins_t s1_q;
  btss_pkg::btss_pins_t s2_q;
  btss_pkg::btss_pins_t s3_q;
  btss_pkg::btss_pins_t f_q;

  assign pinsRaw = '{kClk: link.kClk, kClkN: link.kClkN, cClk: link.cClk,
    cClkN: link.cClkN, cycleDefineN: link.cycleDefineN,
    readNotWrite: link.readNotWrite, addr: link.addr,
    nibbleWriteSelN: link.nibbleWriteSelN, laneWriteSelN: link.laneWriteSelN,
    dq: link.dqBus};

  // three stages; a bit moves only once stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= btss_pkg::PINS_IDLE;
      s2_q <= btss_pkg::PINS_IDLE;
      s3_q <= btss_pkg::PINS_IDLE;
      f_q <= btss_pkg::PINS_IDLE;
    end else begin
      s1_q <= pinsRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  // ********************************************************
  // clock edge detection
  // ********************************************************
  logic kPrev_q;
  logic knPrev_q;
  logic cPrev_q;
  logic cnPrev_q;
  logic kRise;
  logic knRise;
  logic outPosRise;
  logic outNegRise;

  // previous filtered clock levels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      kPrev_q <= 1'b0;
      knPrev_q <= 1'b1; // idle level, so no false edge after reset
      cPrev_q <= 1'b0;
      cnPrev_q <= 1'b1; // idle level, so no false edge after reset
    end else begin
      kPrev_q <= f_q.kClk;
      knPrev_q <= f_q.kClkN;
      cPrev_q <= f_q.cClk;
      cnPrev_q <= f_q.cClkN;
    end
  end

  // data and selects ride the same pipeline as the clocks, so they line up
  assign kRise = f_q.kClk & ~kPrev_q;
  assign knRise = f_q.kClkN & ~knPrev_q;
  // single clock mode reuses the input pair for launching
  assign outPosRise = singleClock ? kRise : (f_q.cClk & ~cPrev_q);
  assign outNegRise = singleClock ? knRise : (f_q.cClkN & ~cnPrev_q);

  // ********************************************************
  // command decode
  // ********************************************************
  logic newRead;
  logic newWrite;

  // load low on a k rise defines the cycle; high leaves the port alone
  assign newRead = kRise & ~f_q.cycleDefineN & f_q.readNotWrite;
  assign newWrite = kRise & ~f_q.cycleDefineN & ~f_q.readNotWrite;

  // word address of one burst beat
  function automatic logic [MAW-1:0] wordAddr(
    input logic [AW-1:0] a,
    input logic second
  );
    logic burstStartBit;
    burstStartBit = a[btss_pkg::A_BURST_BIT];
    if (CFG == btss_pkg::CFG_X8 || CFG == btss_pkg::CFG_X9) begin
      wordAddr = {a, second};
    end else if (CFG == btss_pkg::CFG_X18) begin
      wordAddr = {1'b0, a[AW-1:1], burstStartBit ^ second};
    end else begin
      wordAddr = {2'b00, a[AW-2:1], burstStartBit ^ second};
    end
  endfunction : wordAddr

  // ********************************************************
  // write sequence
  // ********************************************************
  logic wrPend_q;
  logic wrSecond_q;
  logic [AW-1:0] wrAddr_q;
  logic [AW-1:0] wr1Addr_q;

  // word0 on the k rise after the load, word1 on the kn rise after that
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrSecond_q <= 1'b0;
      wrAddr_q <= '0;
      wr1Addr_q <= '0;
    end else begin
      if (kRise) begin
        wrPend_q <= newWrite;
        wrSecond_q <= wrPend_q;
        if (wrPend_q) begin
          wr1Addr_q <= wrAddr_q;
        end
        if (newWrite) begin
          wrAddr_q <= f_q.addr;
        end
      end else if (knRise) begin
        wrSecond_q <= 1'b0;
      end
    end
  end

  // ********************************************************
  // write merge into the array
  // ********************************************************
  logic [DW-1:0] mem [0:(1 << MAW)-1];
  logic [DW-1:0] bitEn;
  logic wrStrobe;
  logic [MAW-1:0] wrWord;

  // per bit enable from the select sampled beside this very word
  for (genvar i = 0; i < DW; i++) begin : g_bitEn
    if (i >= WIDTH) begin : g_unused
      assign bitEn[i] = 1'b0;
    end else if (CFG == btss_pkg::CFG_X8) begin : g_nib
      assign bitEn[i] = ~f_q.nibbleWriteSelN[i / btss_pkg::NIB_W];
    end else begin : g_lane
      assign bitEn[i] = ~f_q.laneWriteSelN[i / btss_pkg::LANE_W];
    end
  end

  assign wrStrobe = (kRise & wrPend_q) | (knRise & wrSecond_q);
  assign wrWord = kRise ? wordAddr(wrAddr_q, 1'b0) : wordAddr(wr1Addr_q, 1'b1);

  // unselected bits keep their stored value; the array has no reset
  always_ff @(posedge clock) begin
    if (wrStrobe) begin
      mem[wrWord] <= (mem[wrWord] & ~bitEn) | (f_q.dq & bitEn);
    end
  end

  // ********************************************************
  // read sequence
  // ********************************************************
  logic rdPend_q;
  logic rdSecond_q;
  logic [AW-1:0] rdAddr_q;
  logic [AW-1:0] rd1Addr_q;
  logic [DW-1:0] dqOut_q;
  logic dqOe_q;

  // in single clock mode load and launch share an edge: the new read wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdPend_q <= 1'b0;
      rdAddr_q <= '0;
    end else begin
      if (newRead) begin
        rdPend_q <= 1'b1;
        rdAddr_q <= f_q.addr;
      end else if (outPosRise) begin
        rdPend_q <= 1'b0;
      end
    end
  end

  // word0 on the positive output edge, word1 on the negative one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdSecond_q <= 1'b0;
      rd1Addr_q <= '0;
      dqOut_q <= '0;
      dqOe_q <= 1'b0;
    end else begin
      if (outPosRise) begin
        dqOe_q <= rdPend_q;
        rdSecond_q <= rdPend_q;
        rd1Addr_q <= rdAddr_q;
        if (rdPend_q) begin
          dqOut_q <= mem[wordAddr(rdAddr_q, 1'b0)] & WMASK;
        end
      end else if (outNegRise && rdSecond_q) begin
        rdSecond_q <= 1'b0;
        dqOut_q <= mem[wordAddr(rd1Addr_q, 1'b1)] & WMASK;
      end
    end
  end

  // drivers stay on only through the burst, then release the bus
  assign link.dqFromMem = dqOut_q;
  assign link.dqMemOe = dqOe_q;

endmodule : btss_mem_end
`default_nettype wire

// File: btss_ctl_end.sv
// controller end of the burst-of-two link, with its read data fifo
`timescale 1ns/1ps
`default_nettype none
module btss_fifo #(
  parameter int W = btss_pkg::DQ_W,
  parameter int DEPTH = btss_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [W-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != FULL);
  assign outValid = (count_q != '0);
  assign outData = store[rdPtr_q];
  assign level = count_q;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : btss_fifo

module btss_ctl_end (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic [btss_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [btss_pkg::DQ_W-1:0] reqData0,
  input wire logic [btss_pkg::DQ_W-1:0] reqData1,
  input wire logic [btss_pkg::LANE_N-1:0] reqSel0N,
  input wire logic [btss_pkg::LANE_N-1:0] reqSel1N,
  output logic rdValid,
  input wire logic rdReady,
  output logic [btss_pkg::DQ_W-1:0] rdData,
  btss_link_if.ctl link
);
  localparam int DW = btss_pkg::DQ_W;
  localparam int LW = $clog2(btss_pkg::FIFO_DEPTH) + 1;
  localparam logic [LW-1:0] ROOM = LW'(btss_pkg::FIFO_DEPTH - btss_pkg::BURST_LEN);

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_LOADED = 3'b001,
    C_WR1 = 3'b010,
    C_WRDONE = 3'b011,
    C_RDLAT = 3'b100,
    C_RD0 = 3'b101,
    C_RD1 = 3'b110
  } btss_cstate_t;

  // ********************************************************
  // link clock divider
  // ********************************************************
  logic [btss_pkg::PH_W-1:0] phase_q;
  logic kClk_q;
  logic kClkN_q;

  // k rises as phase wraps to zero; c pair mirrors k
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= '0;
      kClk_q <= 1'b0;
      kClkN_q <= 1'b1;
    end else begin
      phase_q <= phase_q + 1'b1;
      if (phase_q == btss_pkg::PH_LAST) begin
        kClk_q <= 1'b1;
        kClkN_q <= 1'b0;
      end else if (phase_q == btss_pkg::PH_KFALL) begin
        kClk_q <= 1'b0;
        kClkN_q <= 1'b1;
      end
    end
  end

  // ********************************************************
  // read data synchroniser
  // ********************************************************
  logic [DW-1:0] s1_q;
  logic [DW-1:0] s2_q;
  logic [DW-1:0] s3_q;
  logic [DW-1:0] f_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
    end else begin
      s1_q <= link.dqBus;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  // ********************************************************
  // fifo
  // ********************************************************
  logic pushValid_q;
  logic [DW-1:0] pushData_q;
  logic fifoInReady;
  logic [LW-1:0] fifoLevel;

  btss_fifo #(.W(DW), .DEPTH(btss_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushData_q),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData),
    .level(fifoLevel)
  );

  // ********************************************************
  // transaction sequencer
  // ********************************************************
  btss_cstate_t state_q;
  logic reqReady_q;
  logic take;
  logic isRead_q;
  logic [DW-1:0] data1_q;
  logic [btss_pkg::LANE_N-1:0] sel1N_q;
  logic [DW-1:0] data0_q;
  logic [btss_pkg::LANE_N-1:0] sel0N_q;
  logic cycleDefineN_q;
  logic readNotWrite_q;
  logic [btss_pkg::ADDR_W-1:0] addr_q;
  logic [btss_pkg::LANE_N-1:0] laneSelN_q;
  logic [DW-1:0] dqOut_q;
  logic dqOe_q;

  // offered one cycle ahead, only with room for a whole read burst
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reqReady_q <= 1'b0;
    end else begin
      reqReady_q <= (state_q == C_IDLE) && (phase_q == btss_pkg::PH_PRECMD) &&
        (fifoLevel <= ROOM) && fifoInReady;
    end
  end

  assign take = reqValid & reqReady_q;

  // commands change mid low half of k so they are steady at its rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= C_IDLE;
      isRead_q <= 1'b0;
      data0_q <= '0;
      data1_q <= '0;
      sel0N_q <= '1;
      sel1N_q <= '1;
      cycleDefineN_q <= 1'b1;
      readNotWrite_q <= 1'b1;
      addr_q <= '0;
      laneSelN_q <= '1;
      dqOut_q <= '0;
      dqOe_q <= 1'b0;
      pushValid_q <= 1'b0;
      pushData_q <= '0;
    end else begin
      pushValid_q <= 1'b0;
      unique case (state_q)
        C_IDLE: begin
          if (take) begin
            cycleDefineN_q <= 1'b0;
            readNotWrite_q <= reqRead;
            addr_q <= reqAddr;
            isRead_q <= reqRead;
            data0_q <= reqData0;
            data1_q <= reqData1;
            sel0N_q <= reqSel0N;
            sel1N_q <= reqSel1N;
            state_q <= C_LOADED;
          end
        end
        C_LOADED: begin
          if (phase_q == btss_pkg::PH_CMD) begin
            cycleDefineN_q <= 1'b1;
            if (isRead_q) begin
              state_q <= C_RDLAT;
            end else begin
              dqOut_q <= data0_q;
              laneSelN_q <= sel0N_q;
              dqOe_q <= 1'b1;
              state_q <= C_WR1;
            end
          end
        end
        C_WR1: begin
          if (phase_q == btss_pkg::PH_WORD1) begin
            dqOut_q <= data1_q;
            laneSelN_q <= sel1N_q;
            state_q <= C_WRDONE;
          end
        end
        C_WRDONE: begin
          if (phase_q == btss_pkg::PH_CMD) begin
            dqOe_q <= 1'b0;
            laneSelN_q <= '1;
            state_q <= C_IDLE;
          end
        end
        C_RDLAT: begin
          if (phase_q == btss_pkg::PH_CMD) begin
            state_q <= C_RD0;
          end
        end
        C_RD0: begin
          if (phase_q == btss_pkg::PH_RD0) begin
            pushValid_q <= 1'b1;
            pushData_q <= f_q;
            state_q <= C_RD1;
          end
        end
        C_RD1: begin
          if (phase_q == btss_pkg::PH_RD1) begin
            pushValid_q <= 1'b1;
            pushData_q <= f_q;
            state_q <= C_IDLE;
          end
        end
        default: begin
          state_q <= C_IDLE;
        end
      endcase
    end
  end

  assign reqReady = reqReady_q;
  assign link.kClk = kClk_q;
  assign link.kClkN = kClkN_q;
  assign link.cClk = kClk_q;
  assign link.cClkN = kClkN_q;
  assign link.cycleDefineN = cycleDefineN_q;
  assign link.readNotWrite = readNotWrite_q;
  assign link.addr = addr_q;
  assign link.laneWriteSelN = laneSelN_q;
  assign link.nibbleWriteSelN = laneSelN_q[btss_pkg::NIB_N-1:0];
  assign link.dqFromCtl = dqOut_q;
  assign link.dqCtlOe = dqOe_q;
endmodule : btss_ctl_end
`default_nettype wire

// File: btss_link_monitor.sv
// concurrent checks on the burst-of-two sram link signals
`timescale 1ns/1ps
`default_nettype none
module btss_link_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic cClk,
  input wire logic cycleDefineN,
  input wire logic readNotWrite,
  input wire logic [btss_pkg::ADDR_W-1:0] addr,
  input wire logic [btss_pkg::LANE_N-1:0] laneWriteSelN,
  input wire logic dqCtlOe,
  input wire logic dqMemOe
);
  // ********************************************************
  // helper state
  // ********************************************************
  logic [7:0] rdAge_q;
  // clocks since the last read load; saturates so a stray drive is caught
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdAge_q <= 8'hFF;
    end else if (!cycleDefineN && readNotWrite) begin
      rdAge_q <= 8'h00;
    end else if (rdAge_q != 8'hFF) begin
      rdAge_q <= rdAge_q + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ********************************************************
  // assertions
  // ********************************************************
  chk_kn_inverse: assert property (kClkN == !kClk)
    else $error("input clock pair not complementary");
  chk_c_follows_k: assert property (cClk == kClk)
    else $error("output clock does not follow input clock");
  chk_k_half: assert property ($rose(kClk) |-> ##8 $fell(kClk))
    else $error("input clock high phase wrong");
  chk_load_on_krise: assert property ($fell(cycleDefineN) |-> ##[1:16] ($rose(kClk) && !cycleDefineN))
    else $error("load not seen by an input clock rise");
  chk_cmd_stable: assert property (!cycleDefineN && !$past(cycleDefineN) |-> $stable(addr) && $stable(readNotWrite))
    else $error("address or direction moved during load");
  chk_load_released: assert property ($fell(cycleDefineN) |-> ##[1:17] cycleDefineN)
    else $error("load held low too long");
  chk_write_burst: assert property ($rose(dqCtlOe) |-> dqCtlOe[*8] ##[8:10] !dqCtlOe)
    else $error("write data window wrong length");
  chk_lane_idle: assert property (!dqCtlOe |-> laneWriteSelN == 4'hF)
    else $error("lane selects active outside write data");
  chk_no_contend: assert property (dqCtlOe |-> !dqMemOe)
    else $error("memory drives data during a write");
  chk_read_cause: assert property ($rose(dqMemOe) |-> rdAge_q <= 8'h28)
    else $error("memory drives data with no read loaded");
  chk_read_burst: assert property ($rose(dqMemOe) |-> dqMemOe[*8] ##[4:12] !dqMemOe)
    else $error("read data window wrong length");
  // main scenarios reached
  cov_write: cover property ($rose(dqCtlOe));
  cov_read: cover property ($rose(dqMemOe));
  cov_odd_addr: cover property (!cycleDefineN && addr[0]);
endmodule : btss_link_monitor
`default_nettype wire

// File: burst_two_sram_sync_port_tb.sv
// self-checking bench for the controller and sram ends of the link
`timescale 1ns/1ps
`default_nettype none
module burst_two_sram_sync_port_tb;
  logic clock;
  logic reset_n;
  logic singleClock;
  logic reqValid;
  logic reqReady;
  logic reqRead;
  logic [btss_pkg::ADDR_W-1:0] reqAddr;
  logic [btss_pkg::DQ_W-1:0] reqData0;
  logic [btss_pkg::DQ_W-1:0] reqData1;
  logic [btss_pkg::LANE_N-1:0] reqSel0N;
  logic [btss_pkg::LANE_N-1:0] reqSel1N;
  logic rdValid;
  logic rdReady;
  logic [btss_pkg::DQ_W-1:0] rdData;
  int n_errors;
  int num_checks;
  btss_link_if link ();
  btss_ctl_end btss_ctl_end_inst (.clock(clock), .reset_n(reset_n), .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData0(reqData0),
    .reqData1(reqData1), .reqSel0N(reqSel0N), .reqSel1N(reqSel1N), .rdValid(rdValid),
    .rdReady(rdReady), .rdData(rdData), .link(link));
  btss_mem_end #(.CFG(btss_pkg::CFG_X36)) btss_mem_end_inst (.clock(clock),
    .reset_n(reset_n), .singleClock(singleClock), .link(link));
  btss_link_monitor btss_link_monitor_inst (.clock(clock), .reset_n(reset_n),
    .kClk(link.kClk), .kClkN(link.kClkN), .cClk(link.cClk), .cycleDefineN(link.cycleDefineN),
    .readNotWrite(link.readNotWrite), .addr(link.addr), .laneWriteSelN(link.laneWriteSelN),
    .dqCtlOe(link.dqCtlOe), .dqMemOe(link.dqMemOe));
  // ********************************************************
  // helpers
  // ********************************************************
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  // distinct word per address and beat, so swapped beats show up
  function automatic logic [35:0] wordOf(input logic [19:0] a, input logic b);
    return {8'h5A, a, 7'h00, b};
  endfunction : wordOf
  task automatic set_req(input logic rd, input logic [19:0] a, input logic [35:0] d0,
    input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
    reqRead = rd;
    reqAddr = a;
    reqData0 = d0;
    reqData1 = d1;
    reqSel0N = s0;
    reqSel1N = s1;
    reqValid = 1'b1;
  endtask : set_req
  // ready is a one-cycle pulse, so look for it mid-cycle and drop after the edge
  task automatic wait_taken();
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (reqReady !== 1'b1 && n < 400);
    chk_flag(reqReady, 1'b1);
    @(posedge clock);
    #1 reqValid = 1'b0;
    // let an edge pass so a following request never re-raises valid in this step
    @(posedge clock);
    #1;
  endtask : wait_taken
  task automatic pop(input logic [35:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rdValid !== 1'b1 && n < 400);
    chk_word(rdData, exp);
    @(posedge clock);
    #1 rdReady = 1'b1;
    @(posedge clock);
    #1 rdReady = 1'b0;
  endtask : pop
  task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [35:0] d1,
    input logic [3:0] s0, input logic [3:0] s1);
    set_req(1'b0, a, d0, d1, s0, s1);
    wait_taken();
  endtask : wr
  task automatic rd2(input logic [19:0] a, input logic [35:0] e0, input logic [35:0] e1);
    set_req(1'b1, a, '0, '0, 4'hF, 4'hF);
    wait_taken();
    pop(e0);
    pop(e1);
  endtask : rd2
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_basic();
    logic [19:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 20'(2 * i);
      wr(a, wordOf(a, 1'b0), wordOf(a, 1'b1), 4'h0, 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      a = 20'(2 * i);
      rd2(a, wordOf(a, 1'b0), wordOf(a, 1'b1));
    end
  endtask : t_basic
  // word0 writes lanes 1 and 3, word1 lanes 0 and 2; the rest must survive
  task automatic t_lanes();
    wr(20'h00002, 36'hFFFFFFFFF, 36'h000000000, 4'h5, 4'hA);
    rd2(20'h00002, wordOf(20'h00002, 1'b0) | 36'hFF803FE00,
      wordOf(20'h00002, 1'b1) & ~36'h007FC01FF);
  endtask : t_lanes
  // odd start address swaps beat order; top address bit unused at this width
  task automatic t_burst();
    wr(20'h00007, wordOf(20'h00007, 1'b0), wordOf(20'h00007, 1'b1), 4'h0, 4'h0);
    rd2(20'h00006, wordOf(20'h00007, 1'b1), wordOf(20'h00007, 1'b0));
    rd2(20'h80006, wordOf(20'h00007, 1'b1), wordOf(20'h00007, 1'b0));
  endtask : t_burst
  // reads pile up with the reader stalled until the controller refuses more
  task automatic t_fill();
    logic seen;
    for (int i = 0; i < 8; i++) begin
      set_req(1'b1, 20'h00000, '0, '0, 4'hF, 4'hF);
      wait_taken();
    end
    set_req(1'b1, 20'h00000, '0, '0, 4'hF, 4'hF);
    seen = 1'b0;
    repeat (100) begin
      @(negedge clock);
      seen = seen | (reqReady === 1'b1);
    end
    chk_flag(seen, 1'b0);
    fork
      for (int i = 0; i < 9; i++) begin
        pop(wordOf(20'h00000, 1'b0));
        pop(wordOf(20'h00000, 1'b1));
      end
      wait_taken();
    join
  endtask : t_fill
  task automatic t_single();
    singleClock = 1'b1;
    wr(20'h00008, wordOf(20'h00008, 1'b0), wordOf(20'h00008, 1'b1), 4'h0, 4'h0);
    rd2(20'h00008, wordOf(20'h00008, 1'b0), wordOf(20'h00008, 1'b1));
    singleClock = 1'b0;
  endtask : t_single
  // main sequence
  initial begin
    reset_n = 1'b0;
    singleClock = 1'b0;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqAddr = '0;
    reqData0 = '0;
    reqData1 = '0;
    reqSel0N = 4'hF;
    reqSel1N = 4'hF;
    rdReady = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clock);
    #1 reset_n = 1'b1;
    t_basic();
    t_lanes();
    t_burst();
    t_fill();
    t_single();
    tally_and_finish();
  end
  // watchdog: the whole sequence needs a little over a thousand clocks
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("[FAIL] %0t run hung", $time);
    tally_and_finish();
  end
endmodule : burst_two_sram_sync_port_tb
`default_nettype wire
